// ===== logic/ata_host_pkg.sv
// Package: timing constants and carrier types for the parallel ATA host port
package ata_host_pkg;

  localparam int CLK_PERIOD_NS = 40;

  // Converts a minimum in ns to whole clock cycles, rounding up, at least one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int CNT_W = 6;

  // PIO minimums in ns, modes 0..6
  localparam int PIO_MIN_CYCLE_PERIOD_NS [7]     = '{600, 383, 240, 180, 120, 100, 80};
  localparam int PIO_MIN_COMMAND_ACTIVE_NS [7]   = '{165, 125, 100, 80, 70, 65, 55};
  localparam int PIO_MIN_ACTIVE_8BIT_NS [7]      = '{290, 290, 290, 80, 70, 65, 55};
  localparam int PIO_MIN_COMMAND_RECOVERY_NS [7] = '{0, 0, 0, 70, 25, 25, 20};
  localparam int PIO_ADDR_SETUP_NS [7]           = '{70, 50, 30, 30, 25, 15, 10};
  localparam int PIO_ADDR_HOLD_NS [7]            = '{20, 15, 10, 10, 10, 10, 10};
  localparam int READY_SAMPLE_DELAY_NS           = 35;
  localparam int READY_LOW_MAX_WIDTH_NS          = 1250;

  // Multiword DMA minimums in ns, modes 0..4
  localparam int DMA_MIN_CYCLE_PERIOD_NS [5]    = '{480, 150, 120, 100, 80};
  localparam int DMA_COMMAND_ACTIVE_MIN_NS [5]  = '{215, 80, 70, 65, 55};
  localparam int DMA_READ_NEGATED_MIN_NS [5]    = '{50, 50, 25, 25, 20};
  localparam int DMA_WRITE_NEGATED_MIN_NS [5]   = '{215, 50, 25, 25, 20};
  localparam int DMA_ACK_HOLD_NS [5]            = '{20, 5, 5, 5, 5};

  localparam logic [CNT_W-1:0] READY_SAMPLE_CYC = CNT_W'(ns_to_cyc(READY_SAMPLE_DELAY_NS));
  localparam int READY_LOW_MAX_CYC = READY_LOW_MAX_WIDTH_NS / CLK_PERIOD_NS;

  // Pin bundle toward the device (data/ready/16-bit flag are separate ports)
  typedef struct packed {
    logic       cs0_n;
    logic       cs1_n;
    logic [2:0] addr;
    logic       rd_n;
    logic       wr_n;
    logic       dmack_n;
  } ata_ctl_t;

  // Host-side request
  typedef struct packed {
    logic       dma;
    logic       write;
    logic       byte8;
    logic [1:0] cs;
    logic [2:0] addr;
    logic [15:0] wdata;
  } ata_req_t;

  // Per-mode cycle counts for the selected mode
  typedef struct packed {
    logic [CNT_W-1:0] setup;
    logic [CNT_W-1:0] active;
    logic [CNT_W-1:0] recovery;
    logic [CNT_W-1:0] cycle;
    logic [CNT_W-1:0] hold;
    logic             ready_used;
  } ata_timing_t;

endpackage

// ===== logic/ata_mode_timing.sv
// Selects cycle counts for the chosen PIO or DMA mode
`timescale 1ns/1ps
module ata_mode_timing
  import ata_host_pkg::*;
(
  input  wire logic        dma,
  input  wire logic        write,
  input  wire logic        byte8,
  input  wire logic [2:0]  mode,
  output ata_timing_t      timing
);

  always_comb begin
    timing = '0;
    if (dma) begin
      case (mode)
        3'h0, 3'h1, 3'h2, 3'h3, 3'h4: begin
          timing.setup      = CNT_W'(1);
          timing.active     = CNT_W'(ns_to_cyc(DMA_COMMAND_ACTIVE_MIN_NS[mode]));
          timing.recovery   = write ? CNT_W'(ns_to_cyc(DMA_WRITE_NEGATED_MIN_NS[mode]))
                                    : CNT_W'(ns_to_cyc(DMA_READ_NEGATED_MIN_NS[mode]));
          timing.cycle      = CNT_W'(ns_to_cyc(DMA_MIN_CYCLE_PERIOD_NS[mode]));
          timing.hold       = CNT_W'(ns_to_cyc(DMA_ACK_HOLD_NS[mode]));
          timing.ready_used = 1'b0;
        end
        default: begin
          timing.active     = CNT_W'(ns_to_cyc(DMA_COMMAND_ACTIVE_MIN_NS[0]));
          timing.recovery   = CNT_W'(ns_to_cyc(DMA_WRITE_NEGATED_MIN_NS[0]));
          timing.cycle      = CNT_W'(ns_to_cyc(DMA_MIN_CYCLE_PERIOD_NS[0]));
          timing.setup      = CNT_W'(1);
          timing.hold       = CNT_W'(1);
        end
      endcase
    end else begin
      case (mode)
        3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6: begin
          timing.setup      = CNT_W'(ns_to_cyc(PIO_ADDR_SETUP_NS[mode]));
          timing.active     = byte8 ? CNT_W'(ns_to_cyc(PIO_MIN_ACTIVE_8BIT_NS[mode]))
                                    : CNT_W'(ns_to_cyc(PIO_MIN_COMMAND_ACTIVE_NS[mode]));
          timing.recovery   = CNT_W'(ns_to_cyc(PIO_MIN_COMMAND_RECOVERY_NS[mode]));
          timing.cycle      = CNT_W'(ns_to_cyc(PIO_MIN_CYCLE_PERIOD_NS[mode]));
          timing.hold       = CNT_W'(ns_to_cyc(PIO_ADDR_HOLD_NS[mode]));
          timing.ready_used = (mode < 3'h5);
        end
        default: begin
          timing.setup      = CNT_W'(ns_to_cyc(PIO_ADDR_SETUP_NS[0]));
          timing.active     = CNT_W'(ns_to_cyc(PIO_MIN_ACTIVE_8BIT_NS[0]));
          timing.recovery   = CNT_W'(1);
          timing.cycle      = CNT_W'(ns_to_cyc(PIO_MIN_CYCLE_PERIOD_NS[0]));
          timing.hold       = CNT_W'(1);
          timing.ready_used = 1'b1;
        end
      endcase
    end
  end

endmodule

// ===== logic/ata_host_port.sv
// Host controller driving a parallel ATA task-file port in PIO and multiword DMA
`timescale 1ns/1ps
module ata_host_port
  import ata_host_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic [2:0]  mode,
  input  wire logic        req_valid,
  input  ata_req_t         req,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  output logic             rsp_wide,
  output logic             rsp_timeout,
  output ata_ctl_t         ctl_ff,
  output logic [15:0]      data_out_ff,
  output logic             data_oe_ff,
  input  wire logic [15:0] data_in,
  input  wire logic        iordy,
  input  wire logic        iocs16_n,
  input  wire logic        dmarq
);

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_SETUP  = 5'b00010,
    ST_ACTIVE = 5'b00100,
    ST_WAIT   = 5'b01000,
    ST_RECOV  = 5'b10000
  } state_t;

  state_t           state_ff;
  state_t           nxt_state;
  ata_req_t         req_ff;
  ata_timing_t      timing;
  logic [CNT_W-1:0] phase_cnt_ff;
  logic [CNT_W-1:0] cycle_cnt_ff;
  logic [10:0]      wait_cnt_ff;
  logic [15:0]      data_meta_ff;
  logic [15:0]      data_sync_ff;
  logic [2:0]       pin_meta_ff;
  logic [2:0]       pin_sync_ff;
  logic             ready_s;
  logic             wide_s;
  logic             dmarq_s;
  logic             active_done;
  logic             recov_done;
  logic             wait_over;
  logic             rsp_valid_ff;
  logic [15:0]      rsp_rdata_ff;
  logic             rsp_wide_ff;
  logic             rsp_timeout_ff;

  // Pin values reach the logic one phase after their sample edge
  localparam logic [CNT_W-1:0] READY_SEEN_PHASE = READY_SAMPLE_CYC + CNT_W'(1);
  localparam logic [CNT_W-1:0] DATA_SEEN_PHASE  = CNT_W'(2);

  assign ready_s = pin_sync_ff[0];
  assign wide_s  = ~pin_sync_ff[1];
  assign dmarq_s = pin_sync_ff[2];

  ata_mode_timing u_timing (
    .dma    (req_ff.dma),
    .write  (req_ff.write),
    .byte8  (req_ff.byte8),
    .mode   (mode),
    .timing (timing)
  );

  // Two-stage synchronisers on device pins
  always_ff @(posedge clk) begin
    if (srst) begin
      data_meta_ff <= 16'h0000;
      data_sync_ff <= 16'h0000;
      pin_meta_ff  <= 3'h0;
      pin_sync_ff  <= 3'h0;
    end else if (ce) begin
      data_meta_ff <= data_in;
      data_sync_ff <= data_meta_ff;
      pin_meta_ff  <= {dmarq, iocs16_n, iordy};
      pin_sync_ff  <= pin_meta_ff;
    end
  end

  // DMA words only start while the device requests
  assign req_ready   = (state_ff == ST_IDLE) && (!req.dma || dmarq_s);
  assign active_done = (phase_cnt_ff + CNT_W'(1) >= timing.active)
                       && (phase_cnt_ff >= DATA_SEEN_PHASE);
  assign recov_done  = (phase_cnt_ff + CNT_W'(1) >= timing.recovery)
                       && (phase_cnt_ff + CNT_W'(1) >= timing.hold)
                       && (cycle_cnt_ff + CNT_W'(1) >= timing.cycle);
  assign wait_over   = (32'(wait_cnt_ff) >= READY_LOW_MAX_CYC);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:   if (req_valid && req_ready) nxt_state = ST_SETUP;
      ST_SETUP:  if (phase_cnt_ff + CNT_W'(1) >= timing.setup) nxt_state = ST_ACTIVE;
      ST_ACTIVE: begin
        if (timing.ready_used && phase_cnt_ff == READY_SEEN_PHASE && !ready_s) begin
          nxt_state = ST_WAIT;
        end else if (active_done && (!timing.ready_used || phase_cnt_ff >= READY_SEEN_PHASE)) begin
          nxt_state = ST_RECOV;
        end
      end
      ST_WAIT:   if ((ready_s && active_done) || wait_over) nxt_state = ST_RECOV;
      ST_RECOV:  if (recov_done) nxt_state = ST_IDLE;
      default:   nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // Phase and whole-cycle counters
  always_ff @(posedge clk) begin
    if (srst) begin
      phase_cnt_ff <= '0;
      cycle_cnt_ff <= '0;
      wait_cnt_ff  <= '0;
    end else if (ce) begin
      if (nxt_state != state_ff && !(state_ff == ST_ACTIVE && nxt_state == ST_WAIT)) begin
        phase_cnt_ff <= '0;
      end else if (phase_cnt_ff != '1) begin
        phase_cnt_ff <= phase_cnt_ff + CNT_W'(1);
      end
      if (state_ff == ST_SETUP && nxt_state == ST_ACTIVE) begin
        cycle_cnt_ff <= '0;
      end else if (cycle_cnt_ff != '1) begin
        cycle_cnt_ff <= cycle_cnt_ff + CNT_W'(1);
      end
      if (state_ff == ST_WAIT) begin
        wait_cnt_ff <= wait_cnt_ff + 11'h001;
      end else begin
        wait_cnt_ff <= 11'h000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      req_ff <= '0;
    end else if (ce && state_ff == ST_IDLE && req_valid && req_ready) begin
      req_ff <= req;
    end
  end

  // Pin drive: address/selects, strobes, DMA acknowledge, write data
  always_ff @(posedge clk) begin
    if (srst) begin
      ctl_ff      <= '{cs0_n: 1'b1, cs1_n: 1'b1, addr: 3'h0, rd_n: 1'b1, wr_n: 1'b1, dmack_n: 1'b1};
      data_out_ff <= 16'h0000;
      data_oe_ff  <= 1'b0;
    end else if (ce) begin
      case (nxt_state)
        ST_SETUP: begin
          if (state_ff == ST_IDLE) begin
            ctl_ff.cs0_n   <= req.dma ? 1'b1 : ~req.cs[0];
            ctl_ff.cs1_n   <= req.dma ? 1'b1 : ~req.cs[1];
            ctl_ff.addr    <= req.addr;
            ctl_ff.dmack_n <= ~req.dma;
            data_out_ff    <= req.byte8 ? {8'h00, req.wdata[7:0]} : req.wdata;
            data_oe_ff     <= req.write;
          end
        end
        ST_ACTIVE, ST_WAIT: begin
          ctl_ff.rd_n <= req_ff.write;
          ctl_ff.wr_n <= ~req_ff.write;
        end
        ST_RECOV: begin
          ctl_ff.rd_n <= 1'b1;
          ctl_ff.wr_n <= 1'b1;
        end
        default: begin
          ctl_ff.rd_n    <= 1'b1;
          ctl_ff.wr_n    <= 1'b1;
          ctl_ff.cs0_n   <= 1'b1;
          ctl_ff.cs1_n   <= 1'b1;
          ctl_ff.dmack_n <= 1'b1;
          data_oe_ff     <= 1'b0;
        end
      endcase
    end
  end

  // Read data captured at strobe release; wide flag counted only in modes 0-2
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_valid_ff   <= 1'b0;
      rsp_rdata_ff   <= 16'h0000;
      rsp_wide_ff    <= 1'b0;
      rsp_timeout_ff <= 1'b0;
    end else if (ce) begin
      rsp_valid_ff <= 1'b0;
      if ((state_ff == ST_ACTIVE || state_ff == ST_WAIT) && nxt_state == ST_RECOV) begin
        rsp_valid_ff   <= 1'b1;
        rsp_rdata_ff   <= req_ff.write ? 16'h0000
                          : (req_ff.byte8 ? {8'h00, data_sync_ff[7:0]} : data_sync_ff);
        rsp_wide_ff    <= !req_ff.dma && (mode < 3'h3) && wide_s;
        rsp_timeout_ff <= (state_ff == ST_WAIT) && wait_over;
      end
    end
  end

  assign rsp_valid   = rsp_valid_ff;
  assign rsp_rdata   = rsp_rdata_ff;
  assign rsp_wide    = rsp_wide_ff;
  assign rsp_timeout = rsp_timeout_ff;

endmodule

// ===== tb/ata_host_port_assertions.sv
// Pin protocol checker for the parallel ATA host port
`timescale 1ns/1ps
module ata_host_port_chk
  import ata_host_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [2:0] mode,
  input  ata_ctl_t        ctl_ff,
  input  wire logic       data_oe_ff,
  input  wire logic       iordy
);
  logic       stb;
  logic [5:0] cnt_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  assign stb = ctl_ff.rd_n & ctl_ff.wr_n;
  // Cycles since the last strobe assertion
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff <= 6'h3F;
    end else if ($fell(stb)) begin
      cnt_ff <= 6'h01;
    end else if (cnt_ff != 6'h3F) begin
      cnt_ff <= cnt_ff + 6'h01;
    end
  end
  sequence s_held;
    ($fell(stb) && ctl_ff.dmack_n && mode < 3'h5 && !iordy && !$past(iordy)) ##1 (!iordy) [*3];
  endsequence
  property p_pio_act; $fell(stb) && ctl_ff.dmack_n && mode == 3'h0 |-> (!stb) [*5]; endproperty
  property p_recov; $rose(stb) && ctl_ff.dmack_n && mode == 3'h3 |-> stb [*2]; endproperty
  property p_cycle; $fell(stb) && mode == 3'h0 |-> cnt_ff >= (ctl_ff.dmack_n ? 6'h0F : 6'h0C); endproperty
  property p_hold; s_held |-> !stb; endproperty
  property p_no_wait; $fell(stb) && ctl_ff.dmack_n && mode > 3'h4 |-> ##[1:3] $rose(stb); endproperty
  property p_addr;
    !stb |-> ((!ctl_ff.cs0_n || !ctl_ff.cs1_n) != !ctl_ff.dmack_n) && $stable({ctl_ff.cs0_n, ctl_ff.cs1_n, ctl_ff.addr});
  endproperty
  property p_dma_act; $fell(stb) && !ctl_ff.dmack_n && mode == 3'h0 |-> (!stb) [*6]; endproperty
  property p_dma_neg; $rose(ctl_ff.wr_n) && !ctl_ff.dmack_n && mode == 3'h0 |-> ctl_ff.wr_n [*6]; endproperty
  property p_no_fight; !ctl_ff.rd_n |-> !data_oe_ff; endproperty
  a_pio_act: assert property (p_pio_act) else $error("strobe too short");
  a_recov: assert property (p_recov) else $error("recovery too short");
  a_cycle: assert property (p_cycle) else $error("cycle too short");
  a_hold: assert property (p_hold) else $error("strobe ended while not ready");
  a_no_wait: assert property (p_no_wait) else $error("wait in fast mode");
  a_addr: assert property (p_addr) else $error("select unstable");
  a_dma_act: assert property (p_dma_act) else $error("dma strobe too short");
  a_dma_neg: assert property (p_dma_neg) else $error("dma negated too short");
  a_no_fight: assert property (p_no_fight) else $error("host drives during read");
endmodule

bind ata_host_port ata_host_port_chk u_chk (.clk(clk), .srst(srst), .mode(mode), .ctl_ff(ctl_ff),
  .data_oe_ff(data_oe_ff), .iordy(iordy));

// ===== tb/ata_dev_model.sv
// Device-side model of the task-file port
`timescale 1ns/1ps
module ata_dev_model
  import ata_host_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  ata_ctl_t         ctl,
  input  wire logic [15:0] wdata,
  input  wire logic [5:0]  wait_cyc,
  input  wire logic        load,
  input  wire logic [3:0]  nwords,
  output logic [15:0]      rdata,
  output logic             iordy,
  output logic             iocs16_n,
  output logic             dmarq
);
  logic [15:0] regs_ff [8];
  logic [15:0] dbuf_ff;
  logic [15:0] last_ff;
  logic [5:0]  wcnt_ff;
  logic [3:0]  left_ff;
  logic        stb_ff;
  logic        sel;
  assign sel = !ctl.cs0_n || !ctl.cs1_n;
  assign iordy = !(sel && wcnt_ff < wait_cyc);
  assign iocs16_n = !(!ctl.cs0_n && ctl.addr == 3'h0);
  assign dmarq = left_ff != 4'h0;
  // Data valid from strobe onward, so always ahead of ready
  assign rdata = !ctl.rd_n ? (ctl.dmack_n ? regs_ff[ctl.addr] : dbuf_ff) : ~last_ff;
  always_ff @(posedge clk) begin
    stb_ff <= ctl.rd_n & ctl.wr_n;
    wcnt_ff <= !sel ? 6'h00 : (ctl.rd_n & ctl.wr_n) ? wcnt_ff : wcnt_ff + 6'h01;
    if (!ctl.rd_n) last_ff <= rdata;
    if (!ctl.wr_n && ctl.dmack_n) regs_ff[ctl.addr] <= iocs16_n ? {8'h00, wdata[7:0]} : wdata;
    if (!ctl.wr_n && !ctl.dmack_n) dbuf_ff <= wdata;
    if (srst) left_ff <= 4'h0;
    else if (load) left_ff <= nwords;
    else if (!ctl.dmack_n && !stb_ff && ctl.rd_n && ctl.wr_n && dmarq) left_ff <= left_ff - 4'h1;
  end
endmodule

// ===== tb/test_ata_host_port.sv
// Self-checking bench for the parallel ATA host port
`timescale 1ns/1ps
module test_ata_host_port import ata_host_pkg::*;;
  logic clk, srst, ce, req_valid, req_ready, rsp_valid, rsp_wide, rsp_timeout, doe, iordy, iocs16_n, dmarq, load;
  logic [2:0]  mode;
  logic [15:0] rsp_rdata, dout, din;
  logic [5:0]  wait_cyc;
  logic [3:0]  nwords;
  ata_req_t    req;
  ata_ctl_t    ctl;
  int          n_errors, num_checks;
  ata_host_port DUT (.clk(clk), .srst(srst), .ce(ce), .mode(mode), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_wide(rsp_wide),
    .rsp_timeout(rsp_timeout), .ctl_ff(ctl), .data_out_ff(dout), .data_oe_ff(doe), .data_in(din),
    .iordy(iordy), .iocs16_n(iocs16_n), .dmarq(dmarq));
  ata_dev_model dev (.clk(clk), .srst(srst), .ctl(ctl), .wdata(dout), .wait_cyc(wait_cyc), .load(load),
    .nwords(nwords), .rdata(din), .iordy(iordy), .iocs16_n(iocs16_n), .dmarq(dmarq));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Mode changes only once the port has gone idle
  task automatic set_mode(input logic [2:0] m, input logic [5:0] w);
    repeat (20) @(negedge clk);
    mode = m;
    wait_cyc = w;
    @(negedge clk);
  endtask
  task automatic xfer(input logic d, w, b, input logic [2:0] a, input logic [15:0] wd, output int cyc);
    int k;
    req = '{dma: d, write: w, byte8: b, cs: (d ? 2'h0 : 2'h1), addr: a, wdata: wd};
    req_valid = 1'b1;
    k = 0;
    while (req_ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    cyc = 1;
    while (rsp_valid !== 1'b1 && cyc < 100) begin
      @(negedge clk);
      cyc++;
    end
    chk("answer", 16'h0001, {15'h0, rsp_valid});
  endtask
  task automatic t_pio;
    int c;
    xfer(0, 1, 0, 3'h0, 16'hA55A, c);
    xfer(0, 0, 0, 3'h0, 16'h0000, c);
    chk("word", 16'hA55A, rsp_rdata);
    chk("wide", 16'h0001, {15'h0, rsp_wide});
    xfer(0, 1, 1, 3'h1, 16'h12C3, c);
    xfer(0, 0, 1, 3'h1, 16'h0000, c);
    chk("byte", 16'h00C3, rsp_rdata);
    chk("narrow", 16'h0000, {15'h0, rsp_wide});
  endtask
  task automatic t_modes;
    int c;
    logic [2:0] m [3] = '{3'h3, 3'h4, 3'h6};
    foreach (m[i]) begin
      set_mode(m[i], 6'h00);
      xfer(0, 1, 0, 3'h0, {13'h1DF7, m[i]}, c);
      xfer(0, 0, 0, 3'h0, 16'h0000, c);
      chk("fast word", {13'h1DF7, m[i]}, rsp_rdata);
      chk("wide ignored", 16'h0000, {15'h0, rsp_wide});
    end
  endtask
  task automatic t_wait;
    int c;
    set_mode(3'h0, 6'h0A);
    xfer(0, 0, 0, 3'h0, 16'h0000, c);
    chk("stretched", 16'h0001, {15'h0, c > 12});
    chk("waited data", {13'h1DF7, 3'h6}, rsp_rdata);
    set_mode(3'h5, 6'h0A);
    xfer(0, 0, 0, 3'h0, 16'h0000, c);
    chk("not stretched", 16'h0001, {15'h0, c < 8});
    set_mode(3'h4, 6'h28);
    xfer(0, 1, 0, 3'h2, 16'h0055, c);
    chk("overrun", 16'h0001, {15'h0, rsp_timeout});
  endtask
  task automatic words(input logic [3:0] n);
    nwords = n;
    load = 1'b1;
    @(negedge clk);
    load = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic t_dma;
    int c;
    set_mode(3'h0, 6'h00);
    words(4'h2);
    xfer(1, 1, 0, 3'h0, 16'h5AA5, c);
    xfer(1, 1, 0, 3'h0, 16'h3CC3, c);
    repeat (8) @(negedge clk);
    chk("wr request", 16'h0000, {15'h0, dmarq});
    chk("refused", 16'h0000, {15'h0, req_ready});
    words(4'h1);
    xfer(1, 0, 0, 3'h0, 16'h0000, c);
    chk("dma word", 16'h3CC3, rsp_rdata);
    repeat (4) @(negedge clk);
    chk("rd request", 16'h0000, {15'h0, dmarq});
  endtask
  // Clock enable low must hold off even a pending request
  task automatic t_freeze;
    int c;
    set_mode(3'h0, 6'h00);
    ce = 1'b0;
    req = '{dma: 1'b0, write: 1'b1, byte8: 1'b0, cs: 2'h1, addr: 3'h0, wdata: 16'h0F0F};
    req_valid = 1'b1;
    repeat (5) @(negedge clk);
    chk("frozen select", 16'h0001, {15'h0, ctl.cs0_n});
    ce = 1'b1;
    xfer(0, 1, 0, 3'h0, 16'h0F0F, c);
    xfer(0, 0, 0, 3'h0, 16'h0000, c);
    chk("after freeze", 16'h0F0F, rsp_rdata);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {srst, ce} = 2'b11;
    {req_valid, load} = 2'b00;
    req = '0;
    mode = 3'h0;
    wait_cyc = 6'h00;
    nwords = 4'h0;
    n_errors = 0;
    num_checks = 0;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    t_pio;
    t_modes;
    t_wait;
    t_dma;
    t_freeze;
    close_out;
  end
  initial begin
    #(40 * 4000);
    n_errors++;
    close_out;
  end
endmodule
